// [lpsc_pkg.sv]
// constants of the light/proximity sensor control
package lpsc_pkg;
    // ------------------------------------------------------------
    // link and register map
    // ------------------------------------------------------------
    localparam logic [6:0] LPSC_DEV_ADDR  = 7'h39;
    localparam logic [7:0] LPSC_A_ENABLE  = 8'h00;
    localparam logic [7:0] LPSC_A_LIGHT_INTEGRATION_TIME   = 8'h01;
    localparam logic [7:0] LPSC_A_WTIME   = 8'h03;
    localparam logic [7:0] LPSC_A_LTH     = 8'h04;
    localparam logic [7:0] LPSC_A_PTH     = 8'h08;
    localparam logic [7:0] LPSC_A_PERS    = 8'h0c;
    localparam logic [7:0] LPSC_A_PCOUNT  = 8'h0e;
    localparam logic [7:0] LPSC_A_STATUS  = 8'h10;
    localparam logic [7:0] LPSC_A_DATA    = 8'h11;
    localparam int LPSC_B_PON   = 0;
    localparam int LPSC_B_LEN   = 1;
    localparam int LPSC_B_PEN   = 2;
    localparam int LPSC_B_WEN   = 3;
    localparam int LPSC_B_LIEN  = 4;
    localparam int LPSC_B_PIEN  = 5;
    localparam int LPSC_B_LVAL  = 0;
    localparam int LPSC_B_PVAL  = 1;
    localparam int LPSC_B_LINT  = 4;
    localparam int LPSC_B_PINT  = 5;
    localparam logic [7:0] LPSC_LIGHT_INTEGRATION_TIME_RST = 8'hff;
    // ------------------------------------------------------------
    // timing at 50 MHz
    // ------------------------------------------------------------
    localparam int LPSC_CLK_NS        = 20;
    localparam int LPSC_STEP_NS       = 2720000;
    localparam int LPSC_PULSE_PER_NS  = 16000;
    localparam int LPSC_PULSE_ON_NS   = 7200;
    localparam int LPSC_STEP_CYC      = LPSC_STEP_NS / LPSC_CLK_NS;
    localparam int LPSC_PULSE_CYC     = LPSC_PULSE_PER_NS / LPSC_CLK_NS;
    localparam int LPSC_PULSE_ON_CYC  = LPSC_PULSE_ON_NS / LPSC_CLK_NS;
endpackage

// [lpsc_i2c_slave.sv]
// i2c slave byte engine with register pointer
`timescale 1ns/1ps
module lpsc_i2c_slave
    import lpsc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oe,
    output logic            wr_stb,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data
);
    typedef enum logic [2:0] {
        I_IDLE = 3'h0, I_ADDR = 3'h1, I_AACK = 3'h2, I_RX = 3'h3,
        I_RACK = 3'h4, I_TX = 3'h5, I_TACK = 3'h6
    } lpsc_i2c_e;
    typedef struct packed {
        lpsc_i2c_e  st;
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic       scl_p;
        logic       sda_p;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic       rw;
        logic       first;
        logic       nack;
        logic       oe;
        logic       wr;
    } lpsc_i2c_s;
    lpsc_i2c_s q, n;
    logic scl, sda, rise, fall;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        n.wr = 1'b0;
        n.scl_s = {q.scl_s[0], scl_in};
        n.sda_s = {q.sda_s[0], sda_in};
        scl = q.scl_s[1];
        sda = q.sda_s[1];
        n.scl_p = scl;
        n.sda_p = sda;
        rise = scl & ~q.scl_p;
        fall = ~scl & q.scl_p;
        if (scl && q.scl_p && q.sda_p && !sda) begin
            n.st = I_ADDR;      // start or repeated start
            n.cnt = 4'h0;
            n.first = 1'b1;
            n.oe = 1'b0;
        end else if (scl && q.scl_p && !q.sda_p && sda) begin
            n.st = I_IDLE;      // stop
            n.oe = 1'b0;
        end else if (rise) begin
            if (q.st == I_ADDR || q.st == I_RX || q.st == I_TX) begin
                n.cnt = q.cnt + 4'h1;
            end
            if (q.st == I_ADDR || q.st == I_RX) begin
                n.sh = {q.sh[6:0], sda};
            end
            if (q.st == I_TACK) begin
                n.nack = sda;
            end
        end else if (fall) begin
            case (q.st)
                I_ADDR: if (q.cnt == 4'h8) begin
                    if (q.sh[7:1] == LPSC_DEV_ADDR) begin
                        n.st = I_AACK;
                        n.oe = 1'b1;
                        n.rw = q.sh[0];
                    end else begin
                        n.st = I_IDLE;
                    end
                end
                I_RX: if (q.cnt == 4'h8) begin
                    n.st = I_RACK;
                    n.oe = 1'b1;
                    if (q.first) begin
                        n.ptr = q.sh;   // first byte sets pointer
                        n.first = 1'b0;
                    end else begin
                        n.wr = 1'b1;
                        n.ptr = q.ptr + 8'h1;
                    end
                end
                I_AACK, I_RACK, I_TACK: begin
                    n.cnt = 4'h0;
                    if (q.st == I_TACK && q.nack) begin
                        n.st = I_IDLE;
                        n.oe = 1'b0;
                    end else if (q.st == I_RACK || !q.rw) begin
                        n.st = I_RX;
                        n.oe = 1'b0;
                    end else begin
                        n.st = I_TX;
                        n.sh = rd_data;
                        n.oe = ~rd_data[7];
                        n.ptr = q.ptr + 8'h1;
                    end
                end
                I_TX: begin
                    if (q.cnt == 4'h8) begin
                        n.st = I_TACK;
                        n.oe = 1'b0;
                    end else begin
                        n.oe = ~q.sh[6];
                        n.sh = {q.sh[6:0], 1'b0};
                    end
                end
                default: n.st = I_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '{st: I_IDLE, scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    assign sda_oe  = q.oe;
    assign wr_stb  = q.wr;
    assign wr_addr = q.ptr - 8'h1;   // pointer already advanced past the write
    assign wr_data = q.sh;
    assign rd_addr = q.ptr;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_ack_addr;
        (q.st == I_AACK) && ($past(q.st) == I_ADDR) |-> (q.sh[7:1] == LPSC_DEV_ADDR) && q.oe;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("ack given to foreign address");
endmodule

// [lpsc_top.sv]
// light/proximity sensor control: i2c registers, sequencer, interrupt
`timescale 1ns/1ps
module lpsc_top
    import lpsc_pkg::*;
#(
    parameter int STEP_CYC = LPSC_STEP_CYC
)(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_oe,
    output logic             int_oe,
    output logic             led_driver_sink,
    output logic             light_integrate,
    output logic             low_power,
    input  wire logic [15:0] adc_broadband,
    input  wire logic [15:0] adc_infrared,
    input  wire logic [15:0] adc_prox
);
    typedef enum logic [2:0] {
        S_SLEEP = 3'h0, S_START = 3'h1, S_PROX = 3'h2,
        S_WAIT = 3'h3, S_LIGHT = 3'h4, S_END = 3'h5
    } lpsc_seq_e;
    typedef struct packed {
        lpsc_seq_e   st;
        logic [31:0] div;
        logic [8:0]  steps;
        logic [7:0]  pulses;
        logic [9:0]  pdiv;
        logic [7:0]  enable;
        logic [7:0]  light_integration_time;
        logic [7:0]  wtime;
        logic [7:0]  pcount;
        logic [7:0]  pers;
        logic [31:0] lth;
        logic [31:0] pth;
        logic [15:0] broadband_channel;
        logic [15:0] infrared_channel;
        logic [15:0] prox;
        logic [3:0]  lpc;
        logic [3:0]  ppc;
        logic [7:0]  status;
        logic        led;
        logic        integ;
        logic        lowp;
        logic        intr;
    } lpsc_top_s;
    lpsc_top_s q, n;
    logic       wr_stb;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    logic       step_en, light_done, prox_done, power_on_bit;
    logic [3:0] lpc_n, ppc_n;

    // out-of-window test shared by both functions
    function automatic logic lpsc_outside(input logic [15:0] v, input logic [31:0] th);
        return (v < th[15:0]) || (v > th[31:16]);
    endfunction

    // ------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------
    lpsc_i2c_slave u_i2c (
        .mclk    (mclk),
        .rst     (rst),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .sda_oe  (sda_oe),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    always_comb begin
        rd_data = 8'h00;
        case (rd_addr)
            LPSC_A_ENABLE:       rd_data = q.enable;
            LPSC_A_LIGHT_INTEGRATION_TIME:        rd_data = q.light_integration_time;
            LPSC_A_WTIME:        rd_data = q.wtime;
            LPSC_A_LTH:          rd_data = q.lth[7:0];
            LPSC_A_LTH + 8'h1:   rd_data = q.lth[15:8];
            LPSC_A_LTH + 8'h2:   rd_data = q.lth[23:16];
            LPSC_A_LTH + 8'h3:   rd_data = q.lth[31:24];
            LPSC_A_PTH:          rd_data = q.pth[7:0];
            LPSC_A_PTH + 8'h1:   rd_data = q.pth[15:8];
            LPSC_A_PTH + 8'h2:   rd_data = q.pth[23:16];
            LPSC_A_PTH + 8'h3:   rd_data = q.pth[31:24];
            LPSC_A_PERS:         rd_data = q.pers;
            LPSC_A_PCOUNT:       rd_data = q.pcount;
            LPSC_A_STATUS:       rd_data = q.status;
            LPSC_A_DATA:         rd_data = q.broadband_channel[7:0];
            LPSC_A_DATA + 8'h1:  rd_data = q.broadband_channel[15:8];
            LPSC_A_DATA + 8'h2:  rd_data = q.infrared_channel[7:0];
            LPSC_A_DATA + 8'h3:  rd_data = q.infrared_channel[15:8];
            LPSC_A_DATA + 8'h4:  rd_data = q.prox[7:0];
            LPSC_A_DATA + 8'h5:  rd_data = q.prox[15:8];
            default:             rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // registers, sequencer and interrupt
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        light_done = 1'b0;
        prox_done = 1'b0;
        power_on_bit = q.enable[LPSC_B_PON];
        // step divider restarts on entry to S_WAIT and S_LIGHT so the first step is whole
        step_en = (q.div == 32'(STEP_CYC - 1));
        n.div = step_en ? 32'h0 : q.div + 32'h1;
        if (wr_stb) begin
            case (wr_addr)
                LPSC_A_ENABLE: n.enable = wr_data;
                LPSC_A_LIGHT_INTEGRATION_TIME:  n.light_integration_time = wr_data;
                LPSC_A_WTIME:  n.wtime = wr_data;
                LPSC_A_LTH:    n.lth[7:0] = wr_data;
                LPSC_A_LTH + 8'h1: n.lth[15:8] = wr_data;
                LPSC_A_LTH + 8'h2: n.lth[23:16] = wr_data;
                LPSC_A_LTH + 8'h3: n.lth[31:24] = wr_data;
                LPSC_A_PTH:    n.pth[7:0] = wr_data;
                LPSC_A_PTH + 8'h1: n.pth[15:8] = wr_data;
                LPSC_A_PTH + 8'h2: n.pth[23:16] = wr_data;
                LPSC_A_PTH + 8'h3: n.pth[31:24] = wr_data;
                LPSC_A_PERS:   n.pers = wr_data;
                LPSC_A_PCOUNT: n.pcount = wr_data;
                LPSC_A_STATUS: n.status = q.status & ~wr_data;
                default:       n = n;
            endcase
        end
        case (q.st)
            S_SLEEP: if (power_on_bit) begin
                n.st = S_START;
            end
            S_START: begin
                n.div = 32'h0;
                n.steps = 9'h0;
                n.pulses = 8'h0;
                n.pdiv = 10'h0;
                if (!power_on_bit) begin
                    n.st = S_SLEEP;
                end else if (q.enable[LPSC_B_PEN] && q.pcount != 8'h00) begin
                    n.st = S_PROX;
                end else if (q.enable[LPSC_B_WEN]) begin
                    n.st = S_WAIT;
                end else if (q.enable[LPSC_B_LEN]) begin
                    n.st = S_LIGHT;
                end else begin
                    n.st = S_END;
                end
            end
            // led burst, one period per pulse
            S_PROX: begin
                n.pdiv = q.pdiv + 10'h1;
                if (q.pdiv == 10'(LPSC_PULSE_CYC - 1)) begin
                    n.pdiv = 10'h0;
                    n.pulses = q.pulses + 8'h1;
                    if (q.pulses + 8'h1 == q.pcount) begin
                        prox_done = 1'b1;
                        n.prox = adc_prox;
                        n.div = 32'h0;
                        n.st = q.enable[LPSC_B_WEN] ? S_WAIT : q.enable[LPSC_B_LEN] ? S_LIGHT : S_END;
                    end
                end
            end
            // wait of 256 - setting steps
            S_WAIT: if (step_en) begin
                n.steps = q.steps + 9'h1;
                if (q.steps[7:0] == ~q.wtime) begin
                    n.steps = 9'h0;
                    n.st = q.enable[LPSC_B_LEN] ? S_LIGHT : S_END;
                end
            end
            // integration of 256 - setting steps
            S_LIGHT: if (step_en) begin
                n.steps = q.steps + 9'h1;
                if (q.steps[7:0] == ~q.light_integration_time) begin
                    light_done = 1'b1;
                    n.broadband_channel = adc_broadband;
                    n.infrared_channel = adc_infrared;
                    n.steps = 9'h0;
                    n.st = S_END;
                end
            end
            // power-off only takes effect between cycles
            S_END: n.st = power_on_bit ? S_START : S_SLEEP;
            default: n.st = S_SLEEP;
        endcase
        lpc_n = (q.lpc == 4'hf) ? q.lpc : q.lpc + 4'h1;
        ppc_n = (q.ppc == 4'hf) ? q.ppc : q.ppc + 4'h1;
        // light check, set wins over clear
        if (light_done) begin
            n.status[LPSC_B_LVAL] = 1'b1;
            n.lpc = 4'h0;
            if (lpsc_outside(adc_broadband, q.lth)) begin
                n.lpc = lpc_n;
                if (lpc_n >= q.pers[3:0] && q.enable[LPSC_B_LIEN]) begin
                    n.status[LPSC_B_LINT] = 1'b1;
                end
            end
        end
        if (prox_done) begin
            n.status[LPSC_B_PVAL] = 1'b1;
            n.ppc = 4'h0;
            if (lpsc_outside(adc_prox, q.pth)) begin
                n.ppc = ppc_n;
                if (ppc_n >= q.pers[7:4] && q.enable[LPSC_B_PIEN]) begin
                    n.status[LPSC_B_PINT] = 1'b1;
                end
            end
        end
        // pull low only while a flag stands
        n.intr = n.status[LPSC_B_LINT] | n.status[LPSC_B_PINT];
        n.led = (n.st == S_PROX) && (n.pdiv < 10'(LPSC_PULSE_ON_CYC));
        n.integ = (n.st == S_LIGHT);
        n.lowp = (n.st == S_SLEEP) || (n.st == S_WAIT) || (n.st == S_END);
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '{st: S_SLEEP, light_integration_time: LPSC_LIGHT_INTEGRATION_TIME_RST, lowp: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    assign int_oe          = q.intr;
    assign led_driver_sink = q.led;
    assign light_integrate = q.integ;
    assign low_power       = q.lowp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_latch;
        light_done |=> q.broadband_channel == $past(adc_broadband) && q.infrared_channel == $past(adc_infrared);
    endproperty
    a_latch: assert property (p_latch) else $error("light data not latched");
    property p_hold;
        !light_done && !prox_done |=> $stable(q.broadband_channel) && $stable(q.prox);
    endproperty
    a_hold: assert property (p_hold) else $error("data changed between cycles");
    property p_pulses;
        prox_done |-> q.pulses + 8'h1 == q.pcount && q.pcount != 8'h00;
    endproperty
    a_pulses: assert property (p_pulses) else $error("wrong pulse count");
    property p_int_level;
        int_oe && !(wr_stb && wr_addr == LPSC_A_STATUS) |=> int_oe;
    endproperty
    a_int_level: assert property (p_int_level) else $error("interrupt dropped without clear");
    property p_int_cause;
        $rose(int_oe) |-> $past(light_done || prox_done);
    endproperty
    a_int_cause: assert property (p_int_cause) else $error("interrupt without conversion");
    property p_persist;
        $rose(q.status[LPSC_B_LINT]) |-> $past(q.lpc) + 4'h1 >= $past(q.pers[3:0]) || $past(q.lpc) == 4'hf;
    endproperty
    a_persist: assert property (p_persist) else $error("persistence ignored");
    property p_pon;
        q.st == S_SLEEP && power_on_bit |=> q.st == S_START;
    endproperty
    a_pon: assert property (p_pon) else $error("power-on did not start");
    property p_finish;
        q.st == S_LIGHT |=> q.st == S_LIGHT || q.st == S_END;
    endproperty
    a_finish: assert property (p_finish) else $error("light conversion cut short");
    property p_lowp;
        q.st == S_WAIT ##1 q.st == S_WAIT |-> low_power && !light_integrate;
    endproperty
    a_lowp: assert property (p_lowp) else $error("wait not in low power");
    property p_led;
        led_driver_sink |-> q.st == S_PROX;
    endproperty
    a_led: assert property (p_led) else $error("led outside burst");
    c_prox:  cover property (prox_done);
    c_light: cover property (light_done);
    c_int:   cover property ($rose(int_oe));
endmodule

// [lpsc_host.sv]
// i2c host model that reaches the sensor registers
`timescale 1ns/1ps
module lpsc_host
    import lpsc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tq;
        repeat (32) @(posedge mclk);
    endtask
    // start or repeated start; scl held low on return
    task automatic go;
        sda_low <= 1'b0;
        tq;
        scl <= 1'b1;
        tq;
        sda_low <= 1'b1;
        tq;
        scl <= 1'b0;
        tq;
    endtask
    task automatic halt;
        sda_low <= 1'b1;
        tq;
        scl <= 1'b1;
        tq;
        sda_low <= 1'b0;
        tq;
    endtask
    // nine bits; sda only moves a quarter bit after scl falls
    task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        logic [8:0] w;
        logic [8:0] r;
        w = {d, !mack};
        for (int i = 8; i >= 0; i--) begin
            sda_low <= !w[i];
            tq;
            scl <= 1'b1;
            tq;
            r[i] = sda_line;
            tq;
            scl <= 1'b0;
            tq;
        end
        q = r[8:1];
        ack = !r[0];
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] ptr, input int n, input logic [31:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       k;
        go;
        xbyte({a, 1'b0}, 1'b0, q, ok);
        xbyte(ptr, 1'b0, q, k);
        for (int i = 0; i < n; i++) begin
            xbyte(d[8*i +: 8], 1'b0, q, k);
        end
        halt;
    endtask
    // read of n bytes, low byte first, nack on the last
    task automatic rd(input logic [7:0] ptr, input int n, output logic [31:0] v);
        logic [7:0] q;
        logic       k;
        v = '0;
        go;
        xbyte({LPSC_DEV_ADDR, 1'b0}, 1'b0, q, k);
        xbyte(ptr, 1'b0, q, k);
        go;
        xbyte({LPSC_DEV_ADDR, 1'b1}, 1'b0, q, k);
        for (int i = 0; i < n; i++) begin
            xbyte(8'hff, i < n - 1, q, k);
            v[8*i +: 8] = q;
        end
        halt;
    endtask
endmodule

// [tb.sv]
// self-checking bench of the light/proximity sensor control
`timescale 1ns/1ps
module tb;
    import lpsc_pkg::*;
    localparam int STEP = 20;
    logic        mclk;
    logic        rst;
    logic        scl;
    logic        sda_low;
    logic        sda_oe;
    logic        int_oe;
    logic        led;
    logic        li;
    logic        low_power;
    logic [15:0] adc_bb;
    logic [15:0] adc_ir;
    logic [15:0] adc_px;
    logic        led_p;
    logic        li_p;
    logic [31:0] v;
    logic        ok;
    int          n_fail;
    int          checks;
    int          n_led;
    int          n_li;
    int          n_lic;
    // pulled-up sda, low when either side sinks it
    wire sda_line = !(sda_low || sda_oe);

    lpsc_host lpsc_host_inst (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    lpsc_top #(.STEP_CYC(STEP)) lpsc_top_inst (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_oe(sda_oe), .int_oe(int_oe), .led_driver_sink(led), .light_integrate(li),
        .low_power(low_power), .adc_broadband(adc_bb), .adc_infrared(adc_ir), .adc_prox(adc_px));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // pulse and integration counters, read on the falling edge where outputs are settled
    always @(negedge mclk) begin
        led_p <= led;
        li_p <= li;
        if (led === 1'b1 && led_p !== 1'b1) n_led++;
        if (li === 1'b1 && li_p !== 1'b1) n_li++;
        if (li === 1'b1) n_lic++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // wait until low power has held for 100 cycles; bounded
    task automatic settle;
        int s;
        s = 0;
        for (int i = 0; i < 20000 && s < 100; i++) begin
            @(negedge mclk);
            s = (low_power === 1'b1) ? s + 1 : 0;
        end
        chk(s >= 100, 32'h1);
    endtask
    // next entry into low power, seen on falling edges; a run-out waiting for the entry is a mismatch, one waiting for the exit is not
    task automatic lp_rise;
        int i;
        i = 0;
        @(negedge mclk);
        while (low_power === 1'b1 && i < 2000) begin
            @(negedge mclk);
            i++;
        end
        while (low_power !== 1'b1 && i < 4000) begin
            @(negedge mclk);
            i++;
        end
        chk(i < 4000, 32'h1);
    endtask
    task automatic t_reset;
        chk(low_power, 32'h1);
        chk(int_oe, 32'h0);
        lpsc_host_inst.rd(LPSC_A_ENABLE, 2, v);
        chk(v[15:8], 32'hff);
        chk(v[7:0], 32'h0);
        $display("done t_reset");
    endtask
    task automatic t_addr;
        lpsc_host_inst.wr(7'h3a, LPSC_A_WTIME, 1, 32'h55, ok);
        chk(ok, 32'h0);
        lpsc_host_inst.rd(8'h02, 2, v);
        chk(v[15:8], 32'h0);
        chk(v[7:0], 32'h0);
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_PCOUNT, 1, 32'h08, ok);
        chk(ok, 32'h1);
        $display("done t_addr");
    endtask
    // power off lands mid burst; the burst must still finish
    task automatic t_prox;
        n_led = 0;
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_ENABLE, 1, 32'h05, ok);
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_ENABLE, 1, 32'h04, ok);
        chk(low_power, 32'h0);
        settle;
        chk(n_led, 32'd8);
        chk(n_li, 32'd0);
        lpsc_host_inst.rd(LPSC_A_DATA + 8'h04, 2, v);
        chk(v, 32'h0abc);
        $display("done t_prox");
    endtask
    task automatic t_light;
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_LTH, 4, 32'h02000100, ok);
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_LIGHT_INTEGRATION_TIME, 1, 32'hfe, ok);
        n_li = 0;
        n_lic = 0;
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_ENABLE, 1, 32'h13, ok);
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_ENABLE, 1, 32'h12, ok);
        settle;
        chk(n_li > 0, 32'h1);
        chk(n_lic, 2 * STEP * n_li);
        chk(n_led, 32'd8);
        lpsc_host_inst.rd(LPSC_A_DATA, 4, v);
        chk(v, 32'h12340345);
        chk(int_oe, 32'h1);
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_STATUS, 1, 32'h10, ok);
        chk(int_oe, 32'h0);
        $display("done t_light");
    endtask
    // wait length, prox persistence of two and the prox interrupt; one pulse per burst
    task automatic t_wait;
        int w;
        adc_px <= 16'h0000;
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_PERS, 3, 32'h010020, ok);
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_WTIME, 1, 32'hfd, ok);
        lpsc_host_inst.wr(LPSC_DEV_ADDR, LPSC_A_ENABLE, 1, 32'h2d, ok);
        lp_rise;
        // low power spans the wait steps plus the single end cycle
        w = 0;
        while (low_power === 1'b1 && w < 2000) begin
            @(negedge mclk);
            w++;
        end
        chk(w, 3 * STEP + 1);
        chk(int_oe, 32'h0);
        @(posedge mclk);
        adc_px <= 16'h0abc;
        lp_rise;
        chk(int_oe, 32'h0);
        lp_rise;
        chk(int_oe, 32'h1);
        $display("done t_wait");
    endtask
    task automatic wrap_up;
        $display("counts: checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog with room over the expected 82k cycles
    initial begin
        repeat (95000) @(posedge mclk);
        n_fail++;
        wrap_up;
    end
    initial begin
        rst = 1'b1;
        adc_bb = 16'h0345;
        adc_ir = 16'h1234;
        adc_px = 16'h0abc;
        n_fail = 0;
        checks = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset;
        t_addr;
        t_prox;
        t_light;
        t_wait;
        wrap_up;
    end
endmodule
